// ==== hdl/ctps_counter_prescaler.sv ====
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - unscaled counter samples external input directly
// - sample prescaler output on phases two, four
// - prescaler divides input into symmetrical waveform
// - counter increments only after synchronisation latency
// - one scaler, counter or watchdog, never both
// - assignment bit and ratio in option bits
// - counter write clears scaler when counter-assigned
// - watchdog clear clears watchdog, and scaler when watchdog-assigned
// - scaler count never readable nor loadable
// - watchdog on own oscillator, config enabled
module ctps_counter_prescaler
  import ctps_pkg::*;
#(
  parameter int CountWidth = COUNT_W,
  parameter int WdtWidth = WDT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // external count input
  input wire logic extCountInput,
  // option bits and configuration
  input wire logic [OPT_W-1:0] optionBits,
  input wire logic watchdogEnable,
  // counter write port
  input wire logic countWrite,
  input wire logic [CountWidth-1:0] countWriteData,
  // watchdog oscillator tick and clear
  input wire logic watchdogOscTick,
  input wire logic watchdogClearInstr,
  // results
  output logic [CountWidth-1:0] countRegister,
  output logic watchdogTimeout,
  output logic phaseTwo,
  output logic phaseFour
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  if (CountWidth < 1 || WdtWidth < 1) begin : g_bad_width
    $error("counter widths must be at least one bit");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    ctps_phase_t phase;
    logic [SCALER_W-1:0] scaler;
    logic [CountWidth-1:0] count;
    logic [WdtWidth-1:0] wdt;
    logic extPrev;
    logic timeout;
  } ctps_state_t;

  ctps_state_t st_reg;
  ctps_state_t st_next;

  logic scalerAssignSelect;
  logic [RATIO_W-1:0] scaleRatioSelect;
  logic scaledOut;
  logic sampleSrc;
  logic sampled;
  logic countPulse;
  logic extRise;
  logic wdtEvent;
  logic [SCALER_W-1:0] wdtMask;

  // assignment high gives the scaler to the watchdog
  assign scalerAssignSelect = optionBits[OPT_ASSIGN_BIT];
  assign scaleRatioSelect =
    optionBits[OPT_RATIO_LSB +: RATIO_W];

  assign phaseTwo = (st_reg.phase == PH_TWO);
  assign phaseFour = (st_reg.phase == PH_FOUR);

  // ************************************************************
  // prescaler tap and sample source
  // ************************************************************
  assign extRise = extCountInput && !st_reg.extPrev;
  // bit f toggles every 2^f edges: square wave of 2^(f+1)
  assign scaledOut = st_reg.scaler[scaleRatioSelect];
  assign sampleSrc = scalerAssignSelect ? extCountInput
                                        : scaledOut;

  // watchdog postscale 2^f: low f bits all ones
  assign wdtMask = SCALER_W'((9'h001 << scaleRatioSelect) - 9'h001);
  assign wdtEvent = watchdogOscTick &&
    (!scalerAssignSelect ||
     ((st_reg.scaler & wdtMask) == wdtMask));

  ctps_phase_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .phaseTwo(phaseTwo),
    .phaseFour(phaseFour),
    .sampleIn(sampleSrc),
    .sampled(sampled),
    .countPulse(countPulse)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.extPrev = extCountInput;
    st_next.timeout = 1'b0;
    case (st_reg.phase)
      PH_ONE: begin
        st_next.phase = PH_TWO;
      end
      PH_TWO: begin
        st_next.phase = PH_THREE;
      end
      PH_THREE: begin
        st_next.phase = PH_FOUR;
      end
      PH_FOUR: begin
        st_next.phase = PH_ONE;
      end
      default: begin
        st_next.phase = PH_ONE;
      end
    endcase
    // one scaler, stepped only by its owner
    if (!scalerAssignSelect) begin
      if (extRise) begin
        st_next.scaler = st_reg.scaler + 8'h01;
      end
    end else if (watchdogEnable && watchdogOscTick) begin
      st_next.scaler = st_reg.scaler + 8'h01;
    end
    // counter: synchronised pulse, write takes priority
    if (countPulse) begin
      st_next.count = st_reg.count + CountWidth'(1);
    end
    if (countWrite) begin
      st_next.count = countWriteData;
      if (!scalerAssignSelect) begin
        st_next.scaler = SCALER_RST;
      end
    end
    // watchdog from its own oscillator tick
    if (watchdogEnable) begin
      if (wdtEvent) begin
        st_next.wdt = st_reg.wdt + WdtWidth'(1);
        st_next.timeout = &st_reg.wdt;
      end
    end else begin
      st_next.wdt = WDT_RST;
    end
    if (watchdogClearInstr) begin
      st_next.wdt = WDT_RST;
      st_next.timeout = 1'b0;
      if (scalerAssignSelect) begin
        st_next.scaler = SCALER_RST;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.phase <= PH_ONE;
      st_reg.scaler <= SCALER_RST;
      st_reg.count <= CountWidth'(COUNT_RST);
      st_reg.wdt <= WDT_RST;
      st_reg.extPrev <= 1'b0;
      st_reg.timeout <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // scaler count stays internal
  assign countRegister = st_reg.count;
  assign watchdogTimeout = st_reg.timeout;

  // ************************************************************
  // checks
  // ************************************************************
  property p_passthru;
    @(posedge clk) disable iff (!arst_n)
      (scalerAssignSelect && (phaseTwo || phaseFour)) |=>
        (sampled == $past(extCountInput));
  endproperty
  a_passthru: assert property (p_passthru)
    else $error("unscaled sample source differs from input");

  property p_tap;
    @(posedge clk) disable iff (!arst_n)
      (!scalerAssignSelect && (phaseTwo || phaseFour)) |=>
        (sampled == $past(scaledOut));
  endproperty
  a_tap: assert property (p_tap)
    else $error("prescaler tap does not follow ratio bits");

  property p_no_early_inc;
    @(posedge clk) disable iff (!arst_n)
      (!countWrite && !countPulse) |=> $stable(countRegister);
  endproperty
  a_no_early_inc: assert property (p_no_early_inc)
    else $error("counter moved without synchronised pulse");

  property p_inc_latency;
    @(posedge clk) disable iff (!arst_n)
      (scalerAssignSelect && !countWrite && $rose(extCountInput))
        |-> !countPulse;
  endproperty
  a_inc_latency: assert property (p_inc_latency)
    else $error("counter pulse in same cycle as input edge");

  property p_write_clear;
    @(posedge clk) disable iff (!arst_n)
      (countWrite && !scalerAssignSelect) |=> (st_reg.scaler == 8'h00);
  endproperty
  a_write_clear: assert property (p_write_clear)
    else $error("counter write did not clear prescaler");

  property p_wdt_clear;
    @(posedge clk) disable iff (!arst_n)
      (watchdogClearInstr && scalerAssignSelect) |=>
        (st_reg.scaler == 8'h00 && st_reg.wdt == '0 && !watchdogTimeout);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog clear left scaler or watchdog");

  property p_exclusive;
    @(posedge clk) disable iff (!arst_n)
      (scalerAssignSelect && $stable(scalerAssignSelect) &&
       !watchdogOscTick && !watchdogClearInstr && !countWrite)
        |=> $stable(st_reg.scaler);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("watchdog scaler stepped by counter input");

  property p_wdt_off;
    @(posedge clk) disable iff (!arst_n)
      !watchdogEnable |=> (st_reg.wdt == '0 && !watchdogTimeout);
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("disabled watchdog is counting");

  property p_phase_walk;
    @(posedge clk) disable iff (!arst_n)
      phaseTwo |=> !phaseTwo && !phaseFour ##1 phaseFour ##1
        !phaseTwo && !phaseFour ##1 phaseTwo;
  endproperty
  a_phase_walk: assert property (p_phase_walk)
    else $error("phase sequence broken");

  c_direct_count: cover property (@(posedge clk) disable iff (!arst_n)
    scalerAssignSelect && countPulse);
  c_scaled_count: cover property (@(posedge clk) disable iff (!arst_n)
    !scalerAssignSelect && countPulse);
  c_timeout: cover property (@(posedge clk) disable iff (!arst_n)
    watchdogTimeout);
endmodule : ctps_counter_prescaler
`default_nettype wire

// ==== common/ctps_pkg.sv ====
package ctps_pkg;
  // ************************************************************
  // widths and field positions
  // ************************************************************
  localparam int COUNT_W = 8;
  localparam int SCALER_W = 8;
  localparam int RATIO_W = 3;
  localparam int OPT_W = 4;
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int WDT_W = 8;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [SCALER_W-1:0] SCALER_RST = 8'h00;
  localparam logic [WDT_W-1:0] WDT_RST = 8'h00;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int EXT_MIN_LEVEL_TOSC = 2;
  localparam int EXT_MIN_PERIOD_TOSC = 4;
  localparam int EXT_MIN_LEVEL_CYC = EXT_MIN_LEVEL_TOSC;
  // ************************************************************
  // instruction clock phases
  // ************************************************************
  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } ctps_phase_t;
endpackage : ctps_pkg

// ==== hdl/ctps_phase_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module ctps_phase_sync
  import ctps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // phase strobes
  input wire logic phaseTwo,
  input wire logic phaseFour,
  // level to sample and counted edge
  input wire logic sampleIn,
  output logic sampled,
  output logic countPulse
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic level;
    logic prev;
  } ctps_sync_t;

  ctps_sync_t st_reg;
  ctps_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.prev = st_reg.level;
    if (phaseTwo || phaseFour) begin
      st_next.level = sampleIn;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sampled = st_reg.level;
  // counts only after the sampled stage has risen
  assign countPulse = st_reg.level && !st_reg.prev;

  // ************************************************************
  // checks
  // ************************************************************
  property p_sample_phase;
    @(posedge clk) disable iff (!arst_n)
      !(phaseTwo || phaseFour) |=> $stable(sampled);
  endproperty
  a_sample_phase: assert property (p_sample_phase)
    else $error("sampled level moved outside phase two or four");
endmodule : ctps_phase_sync
`default_nettype wire

// ==== test/ctps_ext_source.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// external count source
// ****
module ctps_ext_source #(
  parameter int HighCycles = 2,
  parameter int LowCycles = 2
) (
  // clock and pin
  input wire logic clk,
  output logic extCountInput
);
  initial begin
    extCountInput = 1'b0;
  end
  // pulses, levels held whole cycles, idle low
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1 extCountInput = 1'b1;
      repeat (HighCycles) @(posedge clk);
      #1 extCountInput = 1'b0;
      repeat (LowCycles - 1) @(posedge clk);
    end
  endtask : send
endmodule : ctps_ext_source
`default_nettype wire

// ==== test/test_counter_prescaler_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// bench
// ****
module test_counter_prescaler_sync
  import ctps_pkg::*;
;
  logic clk, arst_n, ext, wdEn, cWr, tick, wdClr, wdTmo, ph2, ph4;
  logic [OPT_W-1:0] opt;
  logic [COUNT_W-1:0] cWrData, cnt, c0;
  logic [7:0] tmo = 8'h00;
  int failures = 0;
  int checked = 0;

  ctps_counter_prescaler u_ctps_counter_prescaler (
    .clk(clk), .arst_n(arst_n), .extCountInput(ext),
    .optionBits(opt), .watchdogEnable(wdEn), .countWrite(cWr),
    .countWriteData(cWrData), .watchdogOscTick(tick),
    .watchdogClearInstr(wdClr), .countRegister(cnt),
    .watchdogTimeout(wdTmo), .phaseTwo(ph2), .phaseFour(ph4)
  );
  ctps_ext_source #(
    .HighCycles(EXT_MIN_LEVEL_CYC),
    .LowCycles(EXT_MIN_LEVEL_CYC)
  ) u_ctps_ext_source (.clk(clk), .extCountInput(ext));

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  always @(posedge clk) begin
    if (wdTmo === 1'b1) tmo <= tmo + 8'h01;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s %h not %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] d);
    cWrData = d;
    cWr = 1'b1;
    step(1);
    cWr = 1'b0;
  endtask : wr
  task automatic mode(input logic [3:0] o);
    opt = o;
    step(5);
    wr(8'h00);
    step(5);
  endtask : mode
  task automatic ticks(input int n);
    tick = 1'b1;
    step(n);
    tick = 1'b0;
    step(3);
  endtask : ticks
  task automatic rst(input logic en);
    arst_n = 1'b0;
    wdEn = en;
    step(3);
    arst_n = 1'b1;
  endtask : rst

  task automatic t_phase();
    logic [7:0] s2, s4;
    for (int i = 0; i < 8; i++) begin
      step(1);
      s2[i] = ph2;
      s4[i] = ph4;
    end
    check(8'($countones(s2)), 8'h02, "phase two rate");
    check(s4, {s2[5:0], s2[7:6]}, "phase four spacing");
    $display("test phase done");
  endtask : t_phase
  task automatic t_direct();
    mode(4'h8);
    u_ctps_ext_source.send(5);
    step(4);
    check(cnt, 8'h05, "direct");
    c0 = cnt;
    fork
      u_ctps_ext_source.send(1);
      begin
        step(2);
        check(cnt, c0, "early");
        step(3);
        check(cnt, c0 + 8'h01, "late");
      end
    join
    $display("test direct done");
  endtask : t_direct
  task automatic t_scaled();
    for (int f = 0; f < 8; f++) begin
      mode(4'(f));
      u_ctps_ext_source.send(3 << (f + 1));
      step(6);
      check(cnt, 8'h03, "ratio");
    end
    mode(4'h1);
    u_ctps_ext_source.send(1);
    step(6);
    wr(8'h10);
    u_ctps_ext_source.send(1);
    step(6);
    check(cnt, 8'h10, "write clr");
    $display("test scaled done");
  endtask : t_scaled
  task automatic t_wdog();
    mode(4'h0);
    wdClr = 1'b1;
    step(1);
    wdClr = 1'b0;
    c0 = tmo;
    ticks(255);
    check(tmo, c0, "wd early");
    ticks(1);
    check(tmo, c0 + 8'h01, "wd wrap");
    opt = 4'h9;
    ticks(1);
    wdClr = 1'b1;
    step(1);
    wdClr = 1'b0;
    c0 = tmo;
    ticks(511);
    check(tmo, c0, "post early");
    ticks(1);
    check(tmo, c0 + 8'h01, "post wrap");
    rst(1'b0);
    opt = 4'h0;
    c0 = tmo;
    ticks(300);
    check(tmo, c0, "wd off");
    rst(1'b1);
    step(1);
    check({7'h00, ph2}, 8'h01, "phase after reset");
    $display("test watchdog done");
  endtask : t_wdog

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    opt = 4'h8;
    cWr = 1'b0;
    cWrData = 8'h00;
    tick = 1'b0;
    wdClr = 1'b0;
    rst(1'b1);
    t_phase();
    t_direct();
    t_scaled();
    t_wdog();
    give_verdict();
  end
endmodule : test_counter_prescaler_sync
`default_nettype wire
